// ===== verilog/nva_pkg.sv
/*
 Constants for the nonvolatile access block: address map, jumper codes,
 clock register layout and socket cycle timing.
 Assumes a 100 MHz system clock.
*/
`default_nettype none
package nva_pkg;
	// Clock and timing
	localparam int CLK_NS = 10;
	localparam int CLK_HZ = 100_000_000;
	localparam int RD_NS = 230;
	localparam int TOES_NS = 55;
	localparam int TWP_NS = 120;
	localparam int TDH_NS = 50;
	localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TOES_CYC = (TOES_NS + CLK_NS - 1) / CLK_NS;
	localparam int TWP_CYC = (TWP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TDH_CYC = (TDH_NS + CLK_NS - 1) / CLK_NS;
	// Address map
	localparam logic [15:0] RTC_BASE_HI = 16'hFFFC;
	localparam logic [14:0] BANK1_BASE_HI = 15'h7FF0;
	localparam logic [14:0] BANK2_BASE_HI = 15'h7FF1;
	localparam logic [10:0] RTC_CLK_OFS = 11'h7F8;
	// Jumper configurations
	localparam logic [2:0] CFG_ROM16K = 3'h1;
	localparam logic [2:0] CFG_ROM32K = 3'h2;
	localparam logic [2:0] CFG_ROM64K = 3'h3;
	localparam logic [2:0] CFG_EE8K = 3'h4;
	localparam logic [2:0] CFG_EE32K = 3'h5;
	// Control register bits and reset value
	localparam int CTL_WRITE = 7;
	localparam int CTL_READ = 6;
	localparam int CTL_STOP = 5;
	localparam logic [7:0] CTL_RST = 8'h20;
	// Clock register indices and counter reset values
	localparam logic [2:0] IX_CTL = 3'h0;
	localparam logic [2:0] IX_SEC = 3'h1;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
endpackage
`default_nettype wire

// ===== verilog/nva_bcd_ctr.sv
/*
 One two-digit BCD counter of the timekeeper chain.
 Assumes the caller keeps lo and hi in valid BCD.
*/
`timescale 1ns/10ps
`default_nettype none
module nva_bcd_ctr #(
	parameter logic [7:0] RST = 8'h00
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Control
	input wire logic inc,
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic [7:0] lo,
	input wire logic [7:0] hi,
	// State
	output logic [7:0] val_q,
	output logic wrap
);
	logic [7:0] val_d;
	wire at_hi = (val_q >= hi);
	wire [7:0] bcd_inc = (val_q[3:0] == 4'h9) ? {val_q[7:4] + 4'h1, 4'h0} : val_q + 8'h01;
	assign wrap = inc & at_hi;
	assign val_d = load ? load_val : (inc ? (at_hi ? lo : bcd_inc) : val_q);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			val_q <= RST;
		end else if (clk_en) begin
			val_q <= val_d;
		end
	end
endmodule // nva_bcd_ctr
`default_nettype wire

// ===== verilog/nva_sock_bank.sv
/*
 One socket bank: two byte-wide chips joined into a word port.
 Assumes go is a one-cycle pulse given only while idle.
*/
`timescale 1ns/10ps
`default_nettype none
module nva_sock_bank (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Request
	input wire logic go,
	input wire logic wr,
	input wire logic [15:0] word_addr,
	input wire logic [15:0] wdata,
	input wire logic [2:0] size_jumper,
	output logic done_q,
	output logic [15:0] rdata_q,
	// Socket pins
	output logic [15:0] sock_addr_q,
	output logic ce_n_q,
	output logic oe_n_q,
	output logic we_n_q,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out_q,
	output logic dq_oe_q
);
	typedef enum logic [4:0] {
		SB_IDLE = 5'b00001,
		SB_READ = 5'b00010,
		SB_SETUP = 5'b00100,
		SB_STROBE = 5'b01000,
		SB_HOLD = 5'b10000
	} nva_sb_e;
	nva_sb_e st_q;
	logic [4:0] cnt_q;
	logic [4:0] lim;
	wire cfg_ok = (size_jumper >= nva_pkg::CFG_ROM16K) && (size_jumper <= nva_pkg::CFG_EE32K);
	wire [2:0] cfg = cfg_ok ? size_jumper : nva_pkg::CFG_ROM64K;
	wire erasable = (cfg == nva_pkg::CFG_EE8K) || (cfg == nva_pkg::CFG_EE32K);
	// Address lines the chip size leaves unused are held low
	wire [15:0] mask = (cfg == nva_pkg::CFG_ROM64K) ? 16'hFFFF :
		(cfg == nva_pkg::CFG_ROM16K) ? 16'h3FFF :
		(cfg == nva_pkg::CFG_EE8K) ? 16'h1FFF : 16'h7FFF;
	always_comb begin
		case (st_q)
			SB_READ: lim = 5'(nva_pkg::RD_CYC);
			SB_SETUP: lim = 5'(nva_pkg::TOES_CYC);
			SB_STROBE: lim = 5'(nva_pkg::TWP_CYC);
			SB_HOLD: lim = 5'(nva_pkg::TDH_CYC);
			default: lim = 5'h01;
		endcase
	end
	wire last = (cnt_q == lim - 5'h01);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= SB_IDLE;
			cnt_q <= 5'h00;
			done_q <= 1'b0;
			rdata_q <= 16'h0000;
			sock_addr_q <= 16'h0000;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			dq_out_q <= 16'h0000;
			dq_oe_q <= 1'b0;
		end else if (clk_en) begin
			done_q <= 1'b0;
			cnt_q <= (st_q == SB_IDLE || last) ? 5'h00 : cnt_q + 5'h01;
			case (st_q)
				SB_IDLE: begin
					if (go && wr && !erasable) begin
						done_q <= 1'b1;
					end else if (go) begin
						sock_addr_q <= word_addr & mask;
						ce_n_q <= 1'b0;
						oe_n_q <= wr;
						dq_out_q <= wdata;
						dq_oe_q <= wr;
						st_q <= wr ? SB_SETUP : SB_READ;
					end
				end
				SB_READ: if (last) begin
					rdata_q <= dq_in;
					ce_n_q <= 1'b1;
					oe_n_q <= 1'b1;
					done_q <= 1'b1;
					st_q <= SB_IDLE;
				end
				SB_SETUP: if (last) begin
					we_n_q <= 1'b0;
					st_q <= SB_STROBE;
				end
				SB_STROBE: if (last) begin
					we_n_q <= 1'b1;
					st_q <= SB_HOLD;
				end
				SB_HOLD: if (last) begin
					ce_n_q <= 1'b1;
					dq_oe_q <= 1'b0;
					done_q <= 1'b1;
					st_q <= SB_IDLE;
				end
				default: st_q <= SB_IDLE;
			endcase
		end
	end
	chk_we_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$fell(we_n_q) |-> !ce_n_q && oe_n_q && $past(!ce_n_q && oe_n_q, 6) && erasable)
		else $error("socket write strobe without enable, idle output or erasable part");
	chk_we_width: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		$fell(we_n_q) |-> !we_n_q [*8] ##1 !we_n_q [*4] ##1 $rose(we_n_q))
		else $error("socket write strobe width wrong");
	chk_addr_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
		go && st_q == SB_IDLE && (!wr || erasable) |=> sock_addr_q == ($past(word_addr) & mask))
		else $error("socket address not taken from word address");
endmodule // nva_sock_bank
`default_nettype wire

// ===== verilog/nva_access.sv
/*
 Nonvolatile access block: two ROM/EEPROM socket banks as word ports and
 a battery-backed timekeeper memory with eight clock registers.
 Assumes the processor holds a request until it sees the acknowledge,
 and that all inputs are synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Each socket bank is one 16-bit word port, even and odd byte chips.
// - Each bank's chip size comes from its own jumper setting.
// - Unset or odd jumper value means 64K by 8 read-only parts.
// - Any bank read, and any write to erasable parts, enables both byte chips together.
// - Erasable parts are written by a plain static-memory write cycle.
// - Ready/busy of erasable parts is never sampled.
// - No write blocking during power transitions.
// - Timekeeper 2 KB image repeats through the 64 KB region at FFFC0000.
// - Clock registers sit at FFFC07F8 to FFFC07FF, byte access.
// - Seven BCD 24-hour time fields plus one control register.
// - Calendar handles 28, 29, 30 and 31 day months with leap years.
// - Clock registers are copies, refreshed from counters once a second.
// - Clock events raise no interrupt.
// - 2040 bytes of storage sit below the clock registers.
// - Storage accesses are never delayed by the clock copy refresh.
// - Any timekeeper write sets the power-up flag to one.
module nva_access #(
	parameter int TICK_CYCLES = nva_pkg::CLK_HZ
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Processor port
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	output logic [15:0] cpu_rdata_q,
	output logic cpu_ack,
	// Bank size jumpers
	input wire logic [2:0] bank1_size_jumper,
	input wire logic [2:0] bank2_size_jumper,
	// Bank 1 sockets
	output logic [15:0] bank1_addr,
	output logic bank1_ce_n,
	output logic bank1_oe_n,
	output logic bank1_we_n,
	input wire logic [15:0] bank1_dq_in,
	output logic [15:0] bank1_dq_out,
	output logic bank1_dq_oe,
	// Bank 2 sockets
	output logic [15:0] bank2_addr,
	output logic bank2_ce_n,
	output logic bank2_oe_n,
	output logic bank2_we_n,
	input wire logic [15:0] bank2_dq_in,
	output logic [15:0] bank2_dq_out,
	output logic bank2_dq_oe,
	// Power-up status
	input wire logic power_up_event,
	output logic power_up_flag_n
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_ACK = 3'b100
	} nva_st_e;
	nva_st_e st_q;
	logic [1:0] bsel_q;
	logic [15:0] b1_rdata;
	logic [15:0] b2_rdata;
	logic b1_done;
	logic b2_done;
	logic [7:0] sram [0:2039];
	logic [7:0] clk_copy_q [0:7];
	logic [7:0] cnt_val [0:7];
	logic [26:0] tick_cnt_q;
	logic dump_q;
	logic pwr_flag_q;
	logic [7:0] sec_v;
	logic [7:0] min_v;
	logic [7:0] hr_v;
	logic [7:0] day_v;
	logic [7:0] date_v;
	logic [7:0] mon_v;
	logic [7:0] yr_v;
	logic sec_w;
	logic min_w;
	logic hr_w;
	logic date_w;
	logic mon_w;
	logic [7:0] dim;

	// Request decode
	wire start = cpu_req && (st_q == ST_IDLE);
	wire rtc_hit = (cpu_addr[31:16] == nva_pkg::RTC_BASE_HI);
	wire [10:0] rtc_ofs = cpu_addr[10:0];
	wire clk_hit = rtc_hit && (rtc_ofs >= nva_pkg::RTC_CLK_OFS);
	wire sram_hit = rtc_hit && !clk_hit;
	wire [2:0] clk_ix = rtc_ofs[2:0];
	wire b1_hit = (cpu_addr[31:17] == nva_pkg::BANK1_BASE_HI);
	wire b2_hit = (cpu_addr[31:17] == nva_pkg::BANK2_BASE_HI);
	wire [15:0] word_addr = cpu_addr[16:1];
	// Byte lane of the timekeeper: even address on the upper lane
	wire [7:0] wbyte = cpu_addr[0] ? cpu_wdata[7:0] : cpu_wdata[15:8];
	wire rtc_wr = start && rtc_hit && cpu_we;
	wire sram_wr = rtc_wr && sram_hit;
	wire clk_wr = rtc_wr && clk_hit;
	wire b1_go = start && b1_hit;
	wire b2_go = start && b2_hit;

	// Control register fields
	wire [7:0] ctl = clk_copy_q[0];
	wire freeze = ctl[nva_pkg::CTL_WRITE] || ctl[nva_pkg::CTL_READ];
	wire osc_run = !ctl[nva_pkg::CTL_STOP] && !ctl[nva_pkg::CTL_WRITE];
	// Leaving write mode loads the counters from the copies
	wire load = clk_wr && (clk_ix == nva_pkg::IX_CTL) && ctl[nva_pkg::CTL_WRITE] &&
		!wbyte[nva_pkg::CTL_WRITE];
	wire tick = osc_run && (tick_cnt_q == 27'(TICK_CYCLES - 1));
	wire leap = (!yr_v[4] && (yr_v[3:0] == 4'h0 || yr_v[3:0] == 4'h4 || yr_v[3:0] == 4'h8)) ||
		(yr_v[4] && (yr_v[3:0] == 4'h2 || yr_v[3:0] == 4'h6));
	always_comb begin
		case (mon_v)
			8'h02: dim = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
			default: dim = 8'h31;
		endcase
	end

	// Counter chain, values in BCD, hours 00 to 23
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ZERO)) u_sec (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(tick), .load(load),
		.load_val(clk_copy_q[1]), .lo(8'h00), .hi(8'h59), .val_q(sec_v), .wrap(sec_w)
	);
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ZERO)) u_min (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(sec_w), .load(load),
		.load_val(clk_copy_q[2]), .lo(8'h00), .hi(8'h59), .val_q(min_v), .wrap(min_w)
	);
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ZERO)) u_hr (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(min_w), .load(load),
		.load_val(clk_copy_q[3]), .lo(8'h00), .hi(8'h23), .val_q(hr_v), .wrap(hr_w)
	);
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ONE)) u_day (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(hr_w), .load(load),
		.load_val(clk_copy_q[4]), .lo(8'h01), .hi(8'h07), .val_q(day_v), .wrap()
	);
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ONE)) u_date (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(hr_w), .load(load),
		.load_val(clk_copy_q[5]), .lo(8'h01), .hi(dim), .val_q(date_v), .wrap(date_w)
	);
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ONE)) u_mon (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(date_w), .load(load),
		.load_val(clk_copy_q[6]), .lo(8'h01), .hi(8'h12), .val_q(mon_v), .wrap(mon_w)
	);
	nva_bcd_ctr #(.RST(nva_pkg::BCD_ZERO)) u_yr (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .inc(mon_w), .load(load),
		.load_val(clk_copy_q[7]), .lo(8'h00), .hi(8'h99), .val_q(yr_v), .wrap()
	);
	assign cnt_val[0] = ctl;
	assign cnt_val[1] = sec_v;
	assign cnt_val[2] = min_v;
	assign cnt_val[3] = hr_v;
	assign cnt_val[4] = day_v;
	assign cnt_val[5] = date_v;
	assign cnt_val[6] = mon_v;
	assign cnt_val[7] = yr_v;

	// One-second prescaler
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt_q <= 27'h0000000;
			dump_q <= 1'b0;
		end else if (clk_en) begin
			tick_cnt_q <= (!osc_run || tick || load) ? 27'h0000000 : tick_cnt_q + 27'h0000001;
			dump_q <= tick;
		end
	end

	// Clock register copies; a processor write wins over the refresh
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 8; i++) begin
				clk_copy_q[i] <= (i == 0) ? nva_pkg::CTL_RST : 8'h00;
			end
		end else if (clk_en) begin
			for (int i = 1; i < 8; i++) begin
				if (dump_q && !freeze) begin
					clk_copy_q[i] <= cnt_val[i];
				end
			end
			if (clk_wr) begin
				clk_copy_q[clk_ix] <= wbyte;
			end
		end
	end

	// General storage, on its own port
	always_ff @(posedge sys_clk) begin
		if (clk_en && sram_wr) begin
			sram[rtc_ofs] <= wbyte;
		end
	end

	// Power-up flag: a timekeeper write sets it, a power-up event clears it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_flag_q <= 1'b0;
		end else if (clk_en) begin
			if (rtc_wr) begin
				pwr_flag_q <= 1'b1;
			end else if (power_up_event) begin
				pwr_flag_q <= 1'b0;
			end
		end
	end
	assign power_up_flag_n = pwr_flag_q;

	// Socket banks; writes pass whatever lanes the processor drives
	nva_sock_bank u_bank1 (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.go(b1_go), .wr(cpu_we), .word_addr(word_addr), .wdata(cpu_wdata),
		.size_jumper(bank1_size_jumper), .done_q(b1_done), .rdata_q(b1_rdata),
		.sock_addr_q(bank1_addr), .ce_n_q(bank1_ce_n), .oe_n_q(bank1_oe_n),
		.we_n_q(bank1_we_n), .dq_in(bank1_dq_in), .dq_out_q(bank1_dq_out),
		.dq_oe_q(bank1_dq_oe)
	);
	nva_sock_bank u_bank2 (
		.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.go(b2_go), .wr(cpu_we), .word_addr(word_addr), .wdata(cpu_wdata),
		.size_jumper(bank2_size_jumper), .done_q(b2_done), .rdata_q(b2_rdata),
		.sock_addr_q(bank2_addr), .ce_n_q(bank2_ce_n), .oe_n_q(bank2_oe_n),
		.we_n_q(bank2_we_n), .dq_in(bank2_dq_in), .dq_out_q(bank2_dq_out),
		.dq_oe_q(bank2_dq_oe)
	);

	// Access sequencing and read data
	wire bank_done = (bsel_q[0] && b1_done) || (bsel_q[1] && b2_done);
	wire [15:0] bank_rd = bsel_q[0] ? b1_rdata : b2_rdata;
	wire [7:0] rtc_rd = clk_hit ? clk_copy_q[clk_ix] : sram[rtc_ofs];
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
			bsel_q <= 2'b00;
			cpu_rdata_q <= 16'h0000;
		end else if (clk_en) begin
			case (st_q)
				ST_IDLE: if (start) begin
					bsel_q <= {b2_hit, b1_hit};
					cpu_rdata_q <= rtc_hit ? {rtc_rd, rtc_rd} : 16'h0000;
					st_q <= (b1_hit || b2_hit) ? ST_BUSY : ST_ACK;
				end
				ST_BUSY: if (bank_done) begin
					cpu_rdata_q <= bank_rd;
					st_q <= ST_ACK;
				end
				ST_ACK: st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	assign cpu_ack = (st_q == ST_ACK);

	// Checks
	sequence s_rtc_write;
		start && rtc_hit && cpu_we;
	endsequence
	chk_pwr_flag_set: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		s_rtc_write |=> power_up_flag_n)
		else $error("timekeeper write did not set power-up flag");
	chk_sram_no_wait: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		start && sram_hit |=> cpu_ack ##1 !cpu_ack)
		else $error("storage access delayed");
	chk_sram_alias: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		start && cpu_addr[31:16] == 16'hFFFC && cpu_addr[10:0] < 11'h7F8 |-> sram_hit)
		else $error("timekeeper alias not decoded");
	chk_copy_refresh: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		dump_q && !freeze && !clk_wr |=> clk_copy_q[1] == $past(sec_v))
		else $error("seconds copy not refreshed");
	chk_copy_frozen: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		!dump_q && !clk_wr |=> $stable(clk_copy_q[1]))
		else $error("seconds copy changed off the refresh");
	chk_osc_stopped: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		ctl[nva_pkg::CTL_STOP] && !load |=> $stable(sec_v) && $stable(hr_v))
		else $error("clock advanced while stopped");
	chk_bcd_range: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sec_v <= 8'h59 && min_v <= 8'h59 && hr_v <= 8'h23 && sec_v[3:0] <= 4'h9)
		else $error("time field out of BCD range");
	chk_feb_wrap: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		hr_w && !load && mon_v == 8'h02 && date_v == 8'h28 && !leap |=> date_v == 8'h01)
		else $error("February did not end on day 28");
	chk_bank_ack: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en)
		st_q == ST_BUSY && bank_done |=> cpu_ack && cpu_rdata_q == $past(bank_rd))
		else $error("bank word not returned");
endmodule // nva_access
`default_nettype wire

// ===== test/nva_sock_model.sv
/*
 Behavioural pair of byte-wide socket chips forming one word bank.
 Assumes registered strobes from the bank and the bank's own clock.
*/
`timescale 1ns/10ps
`default_nettype none
module nva_sock_model (
	// Clock
	input wire logic clk,
	// Socket pins
	input wire logic [15:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	output logic [15:0] dq_in
);
	logic [15:0] mem [int];
	initial dq_in = 16'h0000;
	// Plain static-memory write, no command sequence
	always @(posedge clk) begin
		if (!ce_n && !we_n && dq_oe) mem[addr] = dq_out;
	end
	// Data only while selected with outputs on, else a pattern that moves
	always @(posedge clk) begin
		if (!ce_n && !oe_n && !dq_oe) begin
			dq_in <= mem.exists(addr) ? mem[addr] : {addr[7:0] ^ 8'hA5, addr[15:8] ^ 8'h3C};
		end else begin
			dq_in <= ~dq_in;
		end
	end
endmodule // nva_sock_model
`default_nettype wire

// ===== test/testbench.sv
/*
 Self-checking bench for the nonvolatile access block.
 Assumes a shortened second tick of 20 cycles and behavioural socket chips.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic cpu_req = 1'b0;
	logic cpu_we = 1'b0;
	logic [31:0] cpu_addr = 32'h00000000;
	logic [15:0] cpu_wdata = 16'h0000;
	logic [15:0] cpu_rdata_q;
	logic cpu_ack;
	logic [2:0] bank1_size_jumper = 3'h0;
	logic [2:0] bank2_size_jumper = 3'h0;
	logic power_up_event = 1'b0;
	logic power_up_flag_n;
	logic [15:0] b1_addr, b2_addr, b1_din, b2_din, b1_dout, b2_dout;
	logic b1_ce_n, b1_oe_n, b1_we_n, b1_oe, b2_ce_n, b2_oe_n, b2_we_n, b2_oe;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int we_lows = 0;

	always #5 sys_clk = ~sys_clk;

	nva_access #(.TICK_CYCLES(20)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_rdata_q(cpu_rdata_q), .cpu_ack(cpu_ack), .bank1_size_jumper(bank1_size_jumper),
		.bank2_size_jumper(bank2_size_jumper), .bank1_addr(b1_addr), .bank1_ce_n(b1_ce_n),
		.bank1_oe_n(b1_oe_n), .bank1_we_n(b1_we_n), .bank1_dq_in(b1_din), .bank1_dq_out(b1_dout),
		.bank1_dq_oe(b1_oe), .bank2_addr(b2_addr), .bank2_ce_n(b2_ce_n), .bank2_oe_n(b2_oe_n),
		.bank2_we_n(b2_we_n), .bank2_dq_in(b2_din), .bank2_dq_out(b2_dout), .bank2_dq_oe(b2_oe),
		.power_up_event(power_up_event), .power_up_flag_n(power_up_flag_n));
	nva_sock_model sock1_u (.clk(sys_clk), .addr(b1_addr), .ce_n(b1_ce_n), .oe_n(b1_oe_n),
		.we_n(b1_we_n), .dq_out(b1_dout), .dq_oe(b1_oe), .dq_in(b1_din));
	nva_sock_model sock2_u (.clk(sys_clk), .addr(b2_addr), .ce_n(b2_ce_n), .oe_n(b2_oe_n),
		.we_n(b2_we_n), .dq_out(b2_dout), .dq_oe(b2_oe), .dq_in(b2_din));

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [15:0] pat(input logic [15:0] sa);
		return {sa[7:0] ^ 8'hA5, sa[15:8] ^ 8'h3C};
	endfunction

	function automatic logic [15:0] size_mask(input logic [2:0] cfg);
		case (cfg)
			3'h1: return 16'h3FFF;
			3'h2: return 16'h7FFF;
			3'h4: return 16'h1FFF;
			3'h5: return 16'h7FFF;
			default: return 16'hFFFF;
		endcase
	endfunction

	function automatic logic is_bcd(input logic [7:0] v);
		return v[7:4] <= 4'h9 && v[3:0] <= 4'h9;
	endfunction

	// One processor transfer: request held until the acknowledge is seen
	task automatic xfer(input logic we, input logic [31:0] a, input logic [15:0] wd,
		output logic [15:0] rd, output int lat);
		int n;
		n = 0;
		lat = -1;
		rd = 16'h0000;
		@(posedge sys_clk);
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wdata <= wd;
		while (lat < 0 && n < 100) begin
			@(negedge sys_clk);
			n++;
			if (cpu_ack === 1'b1) begin
				lat = n - 1;
				rd = cpu_rdata_q;
			end
		end
		if (lat < 0) check("ack wait", 32'h0, 32'h1);
		@(posedge sys_clk);
		cpu_req <= 1'b0;
	endtask

	// Timekeeper byte access through a random alias of the region
	task automatic tk(input logic we, input logic [10:0] off, input logic [7:0] b,
		output logic [7:0] got);
		logic [15:0] rd;
		int lat;
		xfer(we, {16'hFFFC, 5'($urandom), off}, off[0] ? {~b, b} : {b, ~b}, rd, lat);
		check("tk latency", lat, 1);
		if (!we) check("tk lanes", rd[15:8], rd[7:0]);
		got = rd[7:0];
	endtask

	always @(negedge sys_clk) begin
		if (arst_n && b1_we_n === 1'b0) begin
			we_lows++;
			check("strobe enables", {b1_ce_n, b1_oe_n}, 2'b01);
		end
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		int seed_v, lat, lows, cfg;
		logic [15:0] rd, wd;
		logic [31:0] a;
		logic [10:0] off;
		logic [7:0] got, b;
		logic [7:0] sh [int];
		seed_v = $urandom(85321);
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(negedge sys_clk);
		check("flag at reset", power_up_flag_n, 1'b0);
		check("ce at reset", b1_ce_n, 1'b1);
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			off = (i == 0) ? 11'h7F7 : (i == 1) ? 11'h000 : 11'($urandom_range(0, 'h7F7));
			b = 8'($urandom);
			tk(1'b1, off, b, got);
			sh[off] = b;
			check("flag after write", power_up_flag_n, 1'b1);
		end
		foreach (sh[k]) begin
			tk(1'b0, 11'(k), 8'h00, got);
			check("storage byte", got, sh[k]);
		end
		$display("storage test done");
		tk(1'b0, 11'h7F8, 8'h00, got);
		check("control reset", got, 8'h20);
		repeat (100) @(posedge sys_clk);
		tk(1'b0, 11'h7F9, 8'h00, got);
		check("stopped seconds", got, 8'h00);
		tk(1'b1, 11'h7F8, 8'h00, got);
		repeat (300) @(posedge sys_clk);
		tk(1'b0, 11'h7F9, 8'h00, got);
		check("running seconds", is_bcd(got) && got >= 8'h12 && got <= 8'h16, 1'b1);
		tk(1'b0, 11'h7FD, 8'h00, got);
		check("date copy", got, 8'h01);
		$display("clock test done");
		// Load 23:59:59 on February 28 in year 01 and leap year 04, then let one second pass with a freeze inside it
		for (int y = 0; y < 2; y++) begin
			tk(1'b1, 11'h7F8, 8'h80, got);
			for (int r = 1; r < 8; r++) begin
				b = (r < 3) ? 8'h59 : (r == 3) ? 8'h23 : (r == 4) ? 8'h03 :
					(r == 5) ? 8'h28 : (r == 6) ? 8'h02 : (y ? 8'h04 : 8'h01);
				tk(1'b1, 11'h7F8 + 11'(r), b, got);
			end
			tk(1'b1, 11'h7F8, 8'h00, got);
			clk_en <= 1'b0;
			repeat (100) @(posedge sys_clk);
			clk_en <= 1'b1;
			repeat (25) @(posedge sys_clk);
			tk(1'b0, 11'h7F9, 8'h00, got);
			check("seconds after freeze", got, 8'h00);
			tk(1'b0, 11'h7FD, 8'h00, got);
			check("month end date", got, y ? 8'h29 : 8'h01);
			tk(1'b0, 11'h7FE, 8'h00, got);
			check("month end month", got, y ? 8'h02 : 8'h03);
		end
		$display("calendar test done");
		for (int i = 0; i < 24; i++) begin
			cfg = i % 8;
			@(posedge sys_clk);
			bank1_size_jumper <= 3'(cfg);
			bank2_size_jumper <= 3'($urandom_range(1, 5));
			@(posedge sys_clk);
			a = 32'hFFE00000 | 32'($urandom & 17'h1FFFF);
			xfer(1'b0, a, 16'h0000, rd, lat);
			check("bank1 word", rd, pat(a[16:1] & size_mask(3'(cfg))));
			a = 32'hFFE20000 | 32'($urandom & 17'h1FFFF) | 32'h1;
			xfer(1'b0, a, 16'h0000, rd, lat);
			check("bank2 word", rd, pat(a[16:1] & size_mask(bank2_size_jumper)));
		end
		$display("bank read test done");
		for (int c = 4; c <= 5; c++) begin
			@(posedge sys_clk);
			bank1_size_jumper <= 3'(c);
			a = 32'hFFE00000 | 32'($urandom & 17'h1FFFF);
			wd = 16'($urandom);
			xfer(1'b1, a, wd, rd, lat);
			check("ee write ack", lat, 25);
			xfer(1'b0, a, 16'h0000, rd, lat);
			check("ee readback", rd, wd);
		end
		@(posedge sys_clk);
		bank1_size_jumper <= 3'h3;
		lows = we_lows;
		a = 32'hFFE00000 | 32'($urandom & 17'h1FFFF);
		xfer(1'b1, a, 16'hFFFF, rd, lat);
		check("rom write ack", lat, 2);
		check("rom strobes", we_lows, lows);
		xfer(1'b0, a, 16'h0000, rd, lat);
		check("rom unchanged", rd, pat(a[16:1]));
		$display("bank write test done");
		@(posedge sys_clk);
		power_up_event <= 1'b1;
		@(posedge sys_clk);
		power_up_event <= 1'b0;
		@(negedge sys_clk);
		check("flag cleared", power_up_flag_n, 1'b0);
		xfer(1'b0, 32'h12345678, 16'h0000, rd, lat);
		check("unmapped read", {rd, 16'(lat)}, 32'h00000001);
		tk(1'b1, 11'h100, 8'h5A, got);
		check("flag set again", power_up_flag_n, 1'b1);
		$display("power flag test done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
